// ===== hw/ulf_line_format.sv
// Serial port core: line format, break, loopback, infrared and flow
// control, with an AXI4-Lite register slave and a transmit FIFO.
// Assumes pins rx, cts_n arrive asynchronously to aclk.
//
// Behaviour
// - Break-force drives the serial output to logic 0 instead of frames.
// - Outside loopback, break holds transmit low until software clears it.
// - Infrared mode with break outside loopback pulses infrared output.
// - Loopback routes break to receiver; infrared output held low.
// - Parity polarity one gives even parity, zero gives odd parity.
// - Parity-enable turns parity insert and check on or off.
// - Stop bit count: one, else 1.5 for 5-bit chars, else two.
// - Receiver checks only the first stop bit of each frame.
// - Length field codes 00 to 11 select 5 to 8 data bits.
// - Infrared-mode bit enables SIR pulse signalling on ir_tx; tx keeps plain serial.
// - Auto flow control only with FIFOs and flow enable both set.
// - Loopback without infrared holds transmit high, loops output back.
`timescale 1ns/1ns
`default_nettype none
module ulf_line_format
  import ulf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial line
  output logic tx,
  input wire logic rx,
  output logic ir_tx,
  // Modem control
  input wire logic cts_n,
  output logic rts_n,
  output logic out1_n,
  output logic out2_n
);

  // ==========================================================
  // Registers
  logic [7:0] lfc_q;
  logic [6:0] mlc_q;
  logic [15:0] div_q;
  logic fifo_en_q;
  logic [1:0] char_length_sel;
  logic stop_len;
  logic parity_on;
  logic parity_polarity;
  logic break_force;
  logic divisor_access_sel;
  logic loopback_sel;
  logic hw_flow_ctrl_on;
  logic infrared_mode_on;

  assign char_length_sel = lfc_q[ULF_LFC_LEN_LSB +: 2];
  assign stop_len = lfc_q[ULF_LFC_STOP];
  assign parity_on = lfc_q[ULF_LFC_PAR_ON];
  assign parity_polarity = lfc_q[ULF_LFC_PAR_POL];
  assign break_force = lfc_q[ULF_LFC_BREAK];
  assign divisor_access_sel = lfc_q[ULF_LFC_DIV_SEL];
  assign loopback_sel = mlc_q[ULF_MLC_LOOP];
  assign hw_flow_ctrl_on = mlc_q[ULF_MLC_FLOW];
  assign infrared_mode_on = mlc_q[ULF_MLC_IR];

  // ==========================================================
  // Bus write side
  logic aw_full_q;
  logic w_full_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_lane0_q;
  logic wr_go;
  logic wr_push;
  logic wr_hit;
  logic fifo_in_ready;

  // Write to the data word with divisor select clear means a push; it stalls while the FIFO is full
  assign wr_push = aw_addr_q == ULF_ADDR_DATA && !divisor_access_sel
    && w_lane0_q;
  assign wr_go = aw_full_q && w_full_q && !bvalid
    && (!wr_push || fifo_in_ready);
  assign awready = !aw_full_q;
  assign wready = !w_full_q;
  assign wr_hit = aw_addr_q == ULF_ADDR_DATA || aw_addr_q == ULF_ADDR_FIFO
    || aw_addr_q == ULF_ADDR_LFC || aw_addr_q == ULF_ADDR_MLC
    || aw_addr_q == ULF_ADDR_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      w_data_q <= wdata;
      w_lane0_q <= wstrb[0];
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= ULF_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? ULF_RESP_OKAY : ULF_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfc_q <= ULF_LFC_RESET;
      mlc_q <= ULF_MLC_RESET;
      div_q <= ULF_DIV_RESET;
      fifo_en_q <= 1'b0;
    end else if (wr_go) begin
      if (aw_addr_q == ULF_ADDR_LFC && w_lane0_q) begin
        lfc_q <= w_data_q[7:0] & ULF_LFC_MASK;
      end
      if (aw_addr_q == ULF_ADDR_MLC && w_lane0_q) begin
        mlc_q <= w_data_q[6:0] & ULF_MLC_MASK;
      end
      if (aw_addr_q == ULF_ADDR_FIFO && w_lane0_q) begin
        fifo_en_q <= w_data_q[ULF_FIFO_EN];
      end
      if (aw_addr_q == ULF_ADDR_DATA && divisor_access_sel) begin
        if (wstrb_lo_ok(w_lane0_q)) begin
          div_q <= w_data_q[15:0];
        end
      end
    end
  end

  function automatic logic wstrb_lo_ok(input logic lane);
    return lane;
  endfunction : wstrb_lo_ok

  // ==========================================================
  // Transmit FIFO; a change of FIFO enable empties it
  logic fifo_flush;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_out_data;
  logic [ULF_FIFO_AW:0] fifo_level;

  assign fifo_flush = wr_go && aw_addr_q == ULF_ADDR_FIFO && w_lane0_q
    && w_data_q[ULF_FIFO_EN] != fifo_en_q;

  ulf_fifo #(
    .WIDTH(ULF_FIFO_WIDTH),
    .DEPTH(ULF_FIFO_DEPTH),
    .AW(ULF_FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(fifo_flush),
    .in_valid(wr_go && wr_push),
    .in_ready(fifo_in_ready),
    .in_data(w_data_q[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ==========================================================
  // Pin synchronisers
  logic [1:0] rx_sync_q;
  logic [1:0] cts_sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync_q <= 2'b11;
      cts_sync_q <= 2'b11;
    end else begin
      rx_sync_q <= {rx_sync_q[0], rx};
      cts_sync_q <= {cts_sync_q[0], cts_n};
    end
  end

  // ==========================================================
  // Flow control
  logic flow_active;
  logic cts_int_n;
  logic rx_valid_q;

  assign flow_active = fifo_en_q && hw_flow_ctrl_on;
  // Loopback feeds request-to-send back as clear-to-send
  assign cts_int_n = loopback_sel ? !mlc_q[ULF_MLC_RTS] : cts_sync_q[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_n <= 1'b1;
      out1_n <= 1'b1;
      out2_n <= 1'b1;
    end else begin
      rts_n <= loopback_sel || !mlc_q[ULF_MLC_RTS]
        || (flow_active && rx_valid_q);
      out1_n <= loopback_sel || !mlc_q[ULF_MLC_OUT1];
      out2_n <= loopback_sel || !mlc_q[ULF_MLC_OUT2];
    end
  end

  // ==========================================================
  // Transmitter
  ulf_state_e tx_st_q;
  logic [15:0] tx_cnt_q;
  logic [1:0] tx_halves_q;
  logic [2:0] tx_idx_q;
  logic [7:0] tx_sh_q;
  logic tx_par_q;
  logic tx_bit_q;
  logic tx_tick;
  logic tx_bit_end;
  logic [2:0] last_idx;
  logic [7:0] len_mask;
  logic line_bit;

  assign last_idx = {1'b0, char_length_sel} + 3'h4;
  assign len_mask = 8'hFF >> (2'h3 - char_length_sel);
  assign tx_tick = tx_cnt_q == '0;
  assign tx_bit_end = tx_tick && tx_halves_q == '0;
  assign fifo_pop = tx_st_q == ULF_S_IDLE && !(flow_active && cts_int_n);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_cnt_q <= '0;
    end else if (tx_st_q == ULF_S_IDLE || tx_tick) begin
      tx_cnt_q <= div_q;
    end else begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q <= ULF_S_IDLE;
      tx_halves_q <= '0;
      tx_idx_q <= '0;
      tx_sh_q <= '0;
      tx_par_q <= 1'b0;
      tx_bit_q <= 1'b1;
    end else begin
      if (tx_tick && tx_halves_q != '0) begin
        tx_halves_q <= tx_halves_q - 1'b1;
      end
      case (tx_st_q)
        ULF_S_IDLE: begin
          tx_bit_q <= 1'b1;
          if (fifo_out_valid && fifo_pop) begin
            tx_sh_q <= fifo_out_data & len_mask;
            tx_par_q <= ^(fifo_out_data & len_mask);
            tx_bit_q <= 1'b0;
            tx_halves_q <= 2'h1;
            tx_st_q <= ULF_S_START;
          end
        end
        ULF_S_START: begin
          if (tx_bit_end) begin
            tx_idx_q <= '0;
            tx_bit_q <= tx_sh_q[0];
            tx_halves_q <= 2'h1;
            tx_st_q <= ULF_S_DATA;
          end
        end
        ULF_S_DATA: begin
          if (tx_bit_end) begin
            tx_halves_q <= 2'h1;
            if (tx_idx_q != last_idx) begin
              tx_idx_q <= tx_idx_q + 1'b1;
              tx_sh_q <= tx_sh_q >> 1;
              tx_bit_q <= tx_sh_q[1];
            end else if (parity_on) begin
              tx_bit_q <= parity_polarity ? tx_par_q : !tx_par_q;
              tx_st_q <= ULF_S_PARITY;
            end else begin
              tx_bit_q <= 1'b1;
              tx_halves_q <= stop_halves(stop_len, char_length_sel);
              tx_st_q <= ULF_S_STOP;
            end
          end
        end
        ULF_S_PARITY: begin
          if (tx_bit_end) begin
            tx_bit_q <= 1'b1;
            tx_halves_q <= stop_halves(stop_len, char_length_sel);
            tx_st_q <= ULF_S_STOP;
          end
        end
        ULF_S_STOP: begin
          if (tx_bit_end) begin
            tx_st_q <= ULF_S_IDLE;
          end
        end
        default: begin
          tx_st_q <= ULF_S_IDLE;
        end
      endcase
    end
  end

  function automatic logic [1:0] stop_halves(input logic two,
                                             input logic [1:0] len);
    if (!two) begin
      return 2'h1;
    end
    return (len == 2'h0) ? 2'h2 : 2'h3;
  endfunction : stop_halves

  // ==========================================================
  // Line drivers
  // break spacing
  assign line_bit = tx_bit_q && !break_force;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx <= 1'b1;
    end else begin
      tx <= loopback_sel ? 1'b1 : line_bit;
    end
  end

  // Pulse in the first half of each zero bit; runs free so a break
  // keeps pulsing even between frames
  logic ir_phase_q;
  logic [15:0] ir_cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_cnt_q <= '0;
      ir_phase_q <= 1'b0;
    end else if (tx_st_q != ULF_S_IDLE) begin
      ir_cnt_q <= tx_cnt_q;
      ir_phase_q <= tx_halves_q != '0;
    end else if (ir_cnt_q == '0) begin
      ir_cnt_q <= div_q;
      ir_phase_q <= !ir_phase_q;
    end else begin
      ir_cnt_q <= ir_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_tx <= 1'b0;
    end else begin
      ir_tx <= infrared_mode_on && !loopback_sel && !line_bit && ir_phase_q;
    end
  end

  // ==========================================================
  // Receiver
  ulf_state_e rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [1:0] rx_halves_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_par_q;
  logic rx_src;
  logic rx_bit_end;
  logic rx_done;
  logic [7:0] rx_data_q;
  logic par_err_q;
  logic frame_err_q;
  logic rx_par_bad;
  logic rd_data_hit;
  logic rd_status_hit;

  assign rx_src = loopback_sel ? line_bit : rx_sync_q[1];
  assign rx_bit_end = rx_cnt_q == '0 && rx_halves_q == '0;
  assign rx_done = rx_st_q == ULF_S_STOP && rx_bit_end;
  assign rx_par_bad = rx_st_q == ULF_S_PARITY && rx_bit_end
    && (rx_par_q ^ rx_src) == parity_polarity;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_q <= '0;
      rx_halves_q <= '0;
    end else if (rx_st_q == ULF_S_IDLE) begin
      rx_cnt_q <= div_q;
      rx_halves_q <= '0;
    end else if (rx_cnt_q != '0) begin
      rx_cnt_q <= rx_cnt_q - 1'b1;
    end else begin
      rx_cnt_q <= div_q;
      rx_halves_q <= (rx_halves_q == '0) ? 2'h1 : rx_halves_q - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= ULF_S_IDLE;
      rx_idx_q <= '0;
      rx_sh_q <= '0;
      rx_par_q <= 1'b0;
    end else begin
      case (rx_st_q)
        ULF_S_IDLE: begin
          if (!rx_src) begin
            rx_st_q <= ULF_S_START;
          end
        end
        ULF_S_START: begin
          if (rx_bit_end) begin
            rx_idx_q <= '0;
            rx_par_q <= 1'b0;
            rx_st_q <= rx_src ? ULF_S_IDLE : ULF_S_DATA;
          end
        end
        ULF_S_DATA: begin
          if (rx_bit_end) begin
            rx_sh_q <= {rx_src, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_src;
            rx_idx_q <= rx_idx_q + 1'b1;
            if (rx_idx_q == last_idx) begin
              rx_st_q <= parity_on ? ULF_S_PARITY : ULF_S_STOP;
            end
          end
        end
        ULF_S_PARITY: begin
          if (rx_bit_end) begin
            rx_st_q <= ULF_S_STOP;
          end
        end
        ULF_S_STOP: begin
          if (rx_bit_end) begin
            rx_st_q <= ULF_S_IDLE;
          end
        end
        default: begin
          rx_st_q <= ULF_S_IDLE;
        end
      endcase
    end
  end

  // Reading clears; a new character in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid_q <= 1'b0;
      rx_data_q <= '0;
    end else if (rx_done) begin
      rx_valid_q <= 1'b1;
      rx_data_q <= rx_sh_q >> (2'h3 - char_length_sel);
    end else if (rd_data_hit) begin
      rx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_err_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      if (rx_par_bad) begin
        par_err_q <= 1'b1;
      end else if (rd_status_hit) begin
        par_err_q <= 1'b0;
      end
      if (rx_done && !rx_src) begin
        frame_err_q <= 1'b1;
      end else if (rd_status_hit) begin
        frame_err_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Bus read side
  assign arready = !rvalid;
  assign rd_data_hit = arvalid && arready && araddr == ULF_ADDR_DATA
    && !divisor_access_sel;
  assign rd_status_hit = arvalid && arready && araddr == ULF_ADDR_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ULF_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= ULF_RESP_OKAY;
      rdata <= '0;
      case (araddr)
        ULF_ADDR_DATA: begin
          rdata[15:0] <= divisor_access_sel ? div_q : {8'h00, rx_data_q};
        end
        ULF_ADDR_FIFO: begin
          rdata[ULF_FIFO_EN] <= fifo_en_q;
        end
        ULF_ADDR_LFC: begin
          rdata[7:0] <= lfc_q;
        end
        ULF_ADDR_MLC: begin
          rdata[6:0] <= mlc_q;
        end
        ULF_ADDR_STATUS: begin
          rdata[ULF_ST_RX_VALID] <= rx_valid_q;
          rdata[ULF_ST_PAR_ERR] <= par_err_q;
          rdata[ULF_ST_FRAME_ERR] <= frame_err_q;
          rdata[ULF_ST_TX_BUSY] <= tx_st_q != ULF_S_IDLE;
          rdata[ULF_ST_TX_EMPTY] <= !fifo_out_valid;
          rdata[ULF_ST_TX_FULL] <= !fifo_in_ready;
          rdata[ULF_ST_LEVEL_LSB +: ULF_FIFO_AW + 1] <= fifo_level;
        end
        default: begin
          rresp <= ULF_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : ulf_line_format
`default_nettype wire

// ===== hw/ulf_pkg.sv
// Constants for the serial line-format block: register map, field
// positions, reset values and timing figures.
// Assumes a 32-bit AXI4-Lite master and a 100 MHz aclk.
package ulf_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] ULF_ADDR_DATA   = 32'h5000_1000;
  localparam logic [31:0] ULF_ADDR_FIFO   = 32'h5000_1008;
  localparam logic [31:0] ULF_ADDR_LFC    = 32'h5000_100C;
  localparam logic [31:0] ULF_ADDR_MLC    = 32'h5000_1010;
  localparam logic [31:0] ULF_ADDR_STATUS = 32'h5000_1014;

  // ==========================================================
  // line_format_control fields
  localparam int ULF_LFC_LEN_LSB = 0;
  localparam int ULF_LFC_STOP    = 2;
  localparam int ULF_LFC_PAR_ON  = 3;
  localparam int ULF_LFC_PAR_POL = 4;
  localparam int ULF_LFC_BREAK   = 6;
  localparam int ULF_LFC_DIV_SEL = 7;
  localparam logic [7:0] ULF_LFC_MASK  = 8'hDF;
  localparam logic [7:0] ULF_LFC_RESET = 8'h00;

  // modem_line_control fields
  localparam int ULF_MLC_RTS   = 1;
  localparam int ULF_MLC_OUT1  = 2;
  localparam int ULF_MLC_OUT2  = 3;
  localparam int ULF_MLC_LOOP  = 4;
  localparam int ULF_MLC_FLOW  = 5;
  localparam int ULF_MLC_IR    = 6;
  localparam logic [6:0] ULF_MLC_MASK  = 7'h7E;
  localparam logic [6:0] ULF_MLC_RESET = 7'h00;

  // FIFO control and status fields
  localparam int ULF_FIFO_EN      = 0;
  localparam int ULF_ST_RX_VALID  = 0;
  localparam int ULF_ST_PAR_ERR   = 1;
  localparam int ULF_ST_FRAME_ERR = 2;
  localparam int ULF_ST_TX_BUSY   = 3;
  localparam int ULF_ST_TX_EMPTY  = 4;
  localparam int ULF_ST_TX_FULL   = 5;
  localparam int ULF_ST_LEVEL_LSB = 8;

  // ==========================================================
  // Half-bit period, in cycles minus one
  localparam logic [15:0] ULF_DIV_RESET = 16'h0003;

  // ==========================================================
  // Transmit FIFO shape
  localparam int ULF_FIFO_WIDTH = 8;
  localparam int ULF_FIFO_DEPTH = 32;
  localparam int ULF_FIFO_AW    = 5;

  localparam logic [1:0] ULF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ULF_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ULF_S_IDLE   = 3'b000,
    ULF_S_START  = 3'b001,
    ULF_S_DATA   = 3'b011,
    ULF_S_PARITY = 3'b010,
    ULF_S_STOP   = 3'b110
  } ulf_state_e;

endpackage : ulf_pkg

// ===== hw/ulf_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ulf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [AW:0] level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign level = wr_q - rd_q;
  assign in_ready = (level != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (level != '0) && !flush;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule : ulf_fifo
`default_nettype wire

// ===== sim/ulf_line_format_asserts.sv
// Port checker for ulf_line_format, bound at the foot.
// Assumes the reset divisor: one bit is 8 aclk cycles.
`timescale 1ns/1ns
`default_nettype none
module ulf_line_format_asserts
  import ulf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Line
  input wire logic tx,
  input wire logic ir_tx,
  input wire logic rts_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================
  // Register bus
  // Data pushes may wait on a full FIFO
  sequence s_wr_both;
    awvalid && awready && wvalid && wready && awaddr != ULF_ADDR_DATA;
  endsequence
  a_write_answer: assert property (s_wr_both |=> ##1 bvalid)
    else $error("write answer late");
  a_write_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write answer dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read answer dropped");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read taken while busy");

  // ==========================================
  // Serial line
  sequence s_bit_low;
    !tx [*8];
  endsequence
  sequence s_ir_half;
    ##4 !ir_tx;
  endsequence
  a_reset_idle: assert property ($rose(aresetn) |-> tx && !ir_tx && rts_n
    && !bvalid && !rvalid) else $error("not idle after reset");
  a_low_width: assert property ($fell(tx) |-> s_bit_low)
    else $error("low bit too short");
  a_ir_pulse: assert property ($rose(ir_tx) |-> s_ir_half)
    else $error("infrared pulse too long");
endmodule : ulf_line_format_asserts

bind ulf_line_format ulf_line_format_asserts u_ulf_line_format_asserts (
  .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .bvalid,
  .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .tx,
  .ir_tx, .rts_n);
`default_nettype wire

// ===== sim/ulf_partner.sv
// Far-end serial device: samples tx mid-bit, sends frames on rx.
// Assumes the reset divisor: one bit is 8 aclk cycles.
`timescale 1ns/1ns
`default_nettype none
module ulf_partner (
  // Clock
  input wire logic aclk,
  // Line
  input wire logic tx,
  output logic rx,
  output logic [11:0] line
);
  initial rx = 1'b1;
  always begin
    @(negedge tx);
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 12; i++) begin
      line[i] = tx;
      repeat (8) @(posedge aclk);
    end
  end
  // Eight bits LSB first, one stop only
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (7) @(posedge aclk);
    end
  endtask : send
endmodule : ulf_partner
`default_nettype wire

// ===== sim/ulf_line_format_tb.sv
// Bench: registers, frame formats, break, infrared, FIFO, receive.
// Assumes the reset divisor: one bit is 8 aclk cycles.
`timescale 1ns/1ns
`default_nettype none
module ulf_line_format_tb import ulf_pkg::*;;
  localparam logic [31:0] UNMAPPED = 32'h5000_1004;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, cts_n = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, tx, rx, ir_tx;
  logic rts_n, out1_n, out2_n;
  logic [1:0] bresp, rresp, r;
  logic [11:0] line;
  int failures = 0;
  int check_count = 0;
  always #5 aclk = ~aclk;
  ulf_line_format u_ulf_line_format (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .tx,
    .rx, .ir_tx, .cts_n, .rts_n, .out1_n, .out2_n);
  ulf_partner u_ulf_partner (.aclk, .tx, .rx, .line);

  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [31:0] a, v);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp),
      32'((a == UNMAPPED) ? ULF_RESP_SLVERR : ULF_RESP_OKAY));
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdchk(input string n, input logic [31:0] a, e);
    rd(a);
    chk(n, d, e);
    chk(n, 32'(r), 32'((a == UNMAPPED) ? ULF_RESP_SLVERR : ULF_RESP_OKAY));
  endtask : rdchk

  // ==========================================
  // Scenarios
  task automatic test_regs;
    rdchk("lfc reset", ULF_ADDR_LFC, 32'h0);
    rdchk("mlc reset", ULF_ADDR_MLC, 32'h0);
    wr(ULF_ADDR_LFC, 32'hBF);
    rdchk("lfc bits", ULF_ADDR_LFC, 32'(8'hBF & ULF_LFC_MASK));
    wr(ULF_ADDR_LFC, 32'h0);
    wr(ULF_ADDR_MLC, 32'h7F);
    rdchk("mlc bits", ULF_ADDR_MLC, 32'(ULF_MLC_MASK));
    chk("modem loop", 32'({rts_n, out1_n, out2_n}), 32'h7);
    wr(ULF_ADDR_MLC, 32'h0E);
    repeat (2) @(posedge aclk);
    chk("modem out", 32'({rts_n, out1_n, out2_n}), 32'h0);
    wr(ULF_ADDR_MLC, 32'h0);
    wr(UNMAPPED, 32'h1);
    rdchk("unmapped", UNMAPPED, 32'h0);
  endtask : test_regs
  task automatic test_frames;
    logic [7:0] cfg [4] = '{8'h00, 8'h0D, 8'h1A, 8'h0F};
    logic [11:0] e;
    logic [7:0] dm;
    int n;
    for (int i = 0; i < 4; i++) begin
      n = 5 + cfg[i][1:0];
      dm = 8'hB5 & ((8'h01 << n) - 8'h01);
      e = '1;
      e[0] = 1'b0;
      for (int k = 0; k < n; k++)
        e[k+1] = dm[k];
      if (cfg[i][3])
        e[n+1] = cfg[i][4] ? ^dm : ~^dm;
      wr(ULF_ADDR_LFC, 32'(cfg[i]));
      wr(ULF_ADDR_DATA, 32'hB5);
      repeat (120) @(posedge aclk);
      chk("frame", 32'(line), 32'(e));
    end
  endtask : test_frames
  task automatic test_break;
    int hi = 0;
    wr(ULF_ADDR_LFC, 32'h40);
    repeat (40) @(posedge aclk);
    chk("break tx", 32'(tx), 32'h0);
    wr(ULF_ADDR_MLC, 32'h40);
    repeat (16) begin
      @(posedge aclk);
      hi += ir_tx;
    end
    chk("ir pulses", 32'(hi), 32'd8);
    wr(ULF_ADDR_MLC, 32'h50);
    repeat (4) @(posedge aclk);
    chk("loop lines", 32'({tx, ir_tx}), 32'h2);
    wr(ULF_ADDR_LFC, 32'h0);
    wr(ULF_ADDR_MLC, 32'h0);
  endtask : test_break
  task automatic test_fifo;
    @(posedge aclk);
    cts_n <= 1'b1;
    wr(ULF_ADDR_FIFO, 32'h1);
    wr(ULF_ADDR_MLC, 32'h20);
    for (int i = 0; i < 32; i++)
      wr(ULF_ADDR_DATA, 32'(i));
    rd(ULF_ADDR_STATUS);
    chk("fifo full", 32'({d[13:8], d[5:3]}), 32'h104);
    cts_n <= 1'b0;
    repeat (300) @(posedge aclk);
    cts_n <= 1'b1;
    repeat (200) @(posedge aclk);
    cts_n <= 1'b0;
    for (int i = 0; i < 40 && !d[ULF_ST_TX_EMPTY]; i++) begin
      repeat (100) @(posedge aclk);
      rd(ULF_ADDR_STATUS);
    end
    repeat (120) @(posedge aclk);
    chk("fifo empty", 32'(d[13:8]), 32'h0);
    // Partner misses back-to-back starts, so send one alone
    wr(ULF_ADDR_DATA, 32'h1F);
    repeat (120) @(posedge aclk);
    chk("last frame", 32'(line), 32'hFFE);
    wr(ULF_ADDR_MLC, 32'h0);
    wr(ULF_ADDR_FIFO, 32'h0);
  endtask : test_fifo
  task automatic test_rx;
    wr(ULF_ADDR_LFC, 32'h07);
    rd(ULF_ADDR_STATUS);
    u_ulf_partner.send(8'h3C);
    u_ulf_partner.send(8'hC3);
    repeat (20) @(posedge aclk);
    rd(ULF_ADDR_STATUS);
    chk("frame err", 32'(d[ULF_ST_FRAME_ERR]), 32'h0);
    rdchk("rx char", ULF_ADDR_DATA, 32'hC3);
  endtask : test_rx

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    $display("regs done");
    test_frames();
    $display("frames done");
    test_break();
    $display("break done");
    test_fifo();
    $display("fifo done");
    test_rx();
    $display("rx done");
    print_verdict();
  end
  // Whole run needs under 8000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict();
  end
endmodule : ulf_line_format_tb
`default_nettype wire
